// [din_alarm_pkg.sv]
// Constants, register map and field layout of the discrete input alarm filter
package din_alarm_pkg;
    localparam int CHANNELS = 12;
    localparam int FLAGS = 32;
    localparam int CLK_MHZ = 250;
    localparam int TICK_MS = 10;
    localparam int TICK_CYCLES_DEF = TICK_MS * 1000 * CLK_MHZ;
    localparam int TICK_W = 22;
    localparam int DELAY_W = 16;
    // Delay settings, in seconds times one hundred (10 ms steps)
    localparam logic [DELAY_W-1:0] DELAY_MIN = 16'h0008;
    localparam logic [DELAY_W-1:0] DELAY_MAX = 16'hFDE8;
    localparam logic [DELAY_W-1:0] DELAY_RST = 16'h0014;
    // Channel configuration word layout
    localparam int CFG_W = 11;
    localparam int POL_BIT = 0;
    localparam int CLS_LSB = 1;
    localparam int CLS_W = 3;
    localparam int SACK_BIT = 4;
    localparam int SEL_LSB = 5;
    localparam int SEL_W = 6;
    localparam logic [CLS_W-1:0] CLS_A = 3'h0;
    localparam logic [CLS_W-1:0] CLS_B = 3'h1;
    localparam logic [CLS_W-1:0] CLS_CTRL = 3'h6;
    localparam logic [SEL_W-1:0] SEL_ALWAYS = 6'h00;
    localparam logic [CFG_W-1:0] CFG_RST = {SEL_ALWAYS, 1'b0, CLS_B, 1'b0};
    // Register byte offsets
    localparam logic [7:0] CH_CFG_BASE = 8'h00;
    localparam logic [7:0] CH_DELAY_BASE = 8'h04;
    localparam logic [7:0] CH_STRIDE = 8'h08;
    localparam logic [7:0] FILT_STATE_OFS = 8'h60;
    localparam logic [7:0] ALARM_STATE_OFS = 8'h64;
    localparam logic [7:0] IRQ_STATUS_OFS = 8'h68;
    localparam logic [7:0] IRQ_ENABLE_OFS = 8'h6C;
    localparam logic [7:0] IRQ_CLEAR_OFS = 8'h70;
    localparam logic [7:0] ACK_OFS = 8'h74;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : din_alarm_pkg

// [din_alarm_filter.sv]
// Discrete input conditioning, delay filter and alarm latch with AXI4-Lite registers
// Contract
// - Per-channel assertion delay 0.08 s to 650.00 s, default 0.20 s.
// - Asserted only after input active for the whole delay; interruption restarts count.
// - Equation logic receives the delayed filtered state, not the raw level.
// - Open-at-rest (default): energized input means asserted.
// - Closed-at-rest broken wire reads as asserted input.
// - Asserted channel executes its configured alarm class.
// - Class is warning A or B (default B), shutdown C-F, or control.
// - Control class: channel is a command only, no alarm raised.
// - Control class: no event history entry; drives equation logic only.
// - Self-acknowledge on: alarm clears itself once fault is gone.
// - Self-acknowledge off (default): alarm stays latched after fault disappears.
// - Control class behaves as self-acknowledging whatever the setting.
// - Monitoring default always: channel evaluated continuously.
// - Monitoring may select one of 32 flags; evaluate only while true.
`timescale 1ns/1ps
module din_alarm_filter
    import din_alarm_pkg::*;
#(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
    input wire logic MCLK,
    input wire logic NRST,
    input wire logic [CHANNELS-1:0] DISCRETE_INPUT_CHANNEL,
    input wire logic [FLAGS-1:0] GATING_LOGIC_FLAG,
    input wire logic EXT_ACK,
    output logic [CHANNELS-1:0] FILTERED_STATE,
    output logic [CHANNELS-1:0] ALARM_ACTIVE,
    output logic [CHANNELS-1:0] EVENT_STROBE,
    output logic WARNING_ALARM,
    output logic SHUTDOWN_ALARM,
    output logic IRQ,
    input wire logic [7:0] AWADDR,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic WVALID,
    output logic WREADY,
    output logic [1:0] BRESP,
    output logic BVALID,
    input wire logic BREADY,
    input wire logic [7:0] ARADDR,
    input wire logic ARVALID,
    output logic ARREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP,
    output logic RVALID,
    input wire logic RREADY
);
    function automatic logic is_ctrl(input logic [CLS_W-1:0] cls);
        return cls >= CLS_CTRL;
    endfunction : is_ctrl

    function automatic logic is_warn(input logic [CLS_W-1:0] cls);
        return (cls == CLS_A) || (cls == CLS_B);
    endfunction : is_warn

    function automatic logic [DELAY_W-1:0] clamp_delay(input logic [DELAY_W-1:0] d);
        return (d < DELAY_MIN) ? DELAY_MIN : ((d > DELAY_MAX) ? DELAY_MAX : d);
    endfunction : clamp_delay

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (s[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // Tick divider
    logic [TICK_W-1:0] tick_cnt;
    logic tick;
    wire tick_wrap = tick_cnt == TICK_W'(TICK_CYCLES - 1);
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            tick_cnt <= '0;
            tick <= 1'b0;
        end else begin
            tick_cnt <= tick_wrap ? '0 : tick_cnt + 1'b1;
            tick <= tick_wrap;
        end
    end
    tick_pulse_a: assert property (@(posedge MCLK) disable iff (!NRST)
        tick |=> !tick)
        else $error("tick enable wider than one cycle");

    // Three-stage synchronizer; value moves only when stages two and three agree
    logic [CHANNELS-1:0] sync1, sync2, sync3, din_q;
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
            din_q <= '0;
        end else begin
            sync1 <= DISCRETE_INPUT_CHANNEL;
            sync2 <= sync1;
            sync3 <= sync2;
            din_q <= (sync2 & sync3) | (din_q & (sync2 | sync3));
        end
    end

    logic [CFG_W-1:0] cfg [CHANNELS];
    logic [DELAY_W-1:0] delay_set [CHANNELS];
    logic [DELAY_W-1:0] cnt [CHANNELS];
    logic [CHANNELS-1:0] filt, alarm, irq_stat, irq_en;
    logic [CHANNELS-1:0] act_vec, mon_vec, done_vec, ctrl_vec, warn_vec, sack_vec, ack_vec;

    genvar g;
    generate
        for (g = 0; g < CHANNELS; g++) begin : ch
            wire [SEL_W-1:0] sel = cfg[g][SEL_LSB +: SEL_W];
            wire [4:0] flag_idx = 5'(sel - 1'b1);
            // Closed-at-rest: open wire reads de-energized, hence asserted
            assign act_vec[g] = cfg[g][POL_BIT] ? ~din_q[g] : din_q[g];
            assign mon_vec[g] = (sel == SEL_ALWAYS) || GATING_LOGIC_FLAG[flag_idx];
            assign done_vec[g] = act_vec[g] & mon_vec[g] & (cnt[g] >= delay_set[g]);
            assign ctrl_vec[g] = is_ctrl(cfg[g][CLS_LSB +: CLS_W]);
            assign warn_vec[g] = is_warn(cfg[g][CLS_LSB +: CLS_W]);
            assign sack_vec[g] = cfg[g][SACK_BIT];

            cnt_clear_a: assert property (@(posedge MCLK) disable iff (!NRST)
                !(act_vec[g] && mon_vec[g]) |=> cnt[g] == '0)
                else $error("delay counter not cleared");
            latch_hold_a: assert property (@(posedge MCLK) disable iff (!NRST)
                alarm[g] && !sack_vec[g] && !ctrl_vec[g] && mon_vec[g] && !ack_vec[g] |=> alarm[g])
                else $error("latched alarm dropped without acknowledge");
            self_clear_a: assert property (@(posedge MCLK) disable iff (!NRST)
                (sack_vec[g] || ctrl_vec[g]) && !done_vec[g] |=> !alarm[g])
                else $error("self-acknowledged alarm still set");
            no_ctrl_alarm_a: assert property (@(posedge MCLK) disable iff (!NRST)
                ctrl_vec[g] ##1 ctrl_vec[g] |-> !ALARM_ACTIVE[g])
                else $error("control channel raised an alarm");
        end
    endgenerate

    // Delay counters saturate at the setting; tick phase gives up to one tick of slack
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            for (int i = 0; i < CHANNELS; i++) begin
                cnt[i] <= '0;
            end
        end else begin
            for (int i = 0; i < CHANNELS; i++) begin
                if (!(act_vec[i] && mon_vec[i])) begin
                    cnt[i] <= '0;
                end else if (tick && cnt[i] < delay_set[i]) begin
                    cnt[i] <= cnt[i] + 1'b1;
                end
            end
        end
    end

    // AXI4-Lite write path: address and data held independently, then applied
    logic aw_full, w_full;
    logic [7:0] aw_q;
    logic [31:0] w_q;
    logic [3:0] ws_q;
    wire aw_take = AWVALID & AWREADY;
    wire w_take = WVALID & WREADY;
    wire wr_do = aw_full & w_full & ~BVALID;
    wire next_aw_full = (aw_full | aw_take) & ~wr_do;
    wire next_w_full = (w_full | w_take) & ~wr_do;
    wire next_bvalid = wr_do | (BVALID & ~BREADY);
    wire [5:0] wr_idx = aw_q[7:2];
    wire wr_ch = wr_idx < 6'(2 * CHANNELS);
    wire [3:0] wr_sel = 4'(wr_idx >> 1);
    wire wr_dly = wr_idx[0];
    wire wr_map = wr_ch || aw_q == IRQ_ENABLE_OFS || aw_q == IRQ_CLEAR_OFS || aw_q == ACK_OFS;
    wire wr_ok = wr_do && wr_map && aw_q[1:0] == 2'h0;
    wire [31:0] wr_old = !wr_ch ? 32'(irq_en) : (wr_dly ? 32'(delay_set[wr_sel]) : 32'(cfg[wr_sel]));
    wire [31:0] wr_val = merge(wr_old, w_q, ws_q);
    wire [31:0] wr_pulse = merge(32'h0, w_q, ws_q);
    wire wr_irq_clr = wr_ok && aw_q == IRQ_CLEAR_OFS;
    wire [CHANNELS-1:0] sw_ack = (wr_ok && aw_q == ACK_OFS) ? wr_pulse[CHANNELS-1:0] : '0;
    assign ack_vec = sw_ack | {CHANNELS{EXT_ACK}};

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            aw_q <= '0;
            w_q <= '0;
            ws_q <= '0;
            AWREADY <= 1'b0;
            WREADY <= 1'b0;
            BVALID <= 1'b0;
            BRESP <= RESP_OKAY;
        end else begin
            aw_full <= next_aw_full;
            w_full <= next_w_full;
            if (aw_take) begin
                aw_q <= AWADDR;
            end
            if (w_take) begin
                w_q <= WDATA;
                ws_q <= WSTRB;
            end
            AWREADY <= ~next_aw_full & ~next_bvalid;
            WREADY <= ~next_w_full & ~next_bvalid;
            BVALID <= next_bvalid;
            if (wr_do) begin
                BRESP <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            for (int i = 0; i < CHANNELS; i++) begin
                cfg[i] <= CFG_RST;
                delay_set[i] <= DELAY_RST;
            end
            irq_en <= '0;
        end else if (wr_ok) begin
            if (wr_ch && wr_dly) begin
                delay_set[wr_sel] <= clamp_delay(wr_val[DELAY_W-1:0]);
            end else if (wr_ch) begin
                cfg[wr_sel] <= wr_val[CFG_W-1:0];
            end else if (aw_q == IRQ_ENABLE_OFS) begin
                irq_en <= wr_val[CHANNELS-1:0];
            end
        end
    end

    // Alarm latch, event strobe and sticky interrupt status
    logic [CHANNELS-1:0] next_alarm;
    wire [CHANNELS-1:0] rise_vec = done_vec & ~filt;
    wire [CHANNELS-1:0] event_vec = rise_vec & ~ctrl_vec;
    wire [CHANNELS-1:0] clr_vec = wr_irq_clr ? wr_pulse[CHANNELS-1:0] : '0;
    always_comb begin
        for (int i = 0; i < CHANNELS; i++) begin
            if (ctrl_vec[i] || !mon_vec[i]) begin
                next_alarm[i] = 1'b0;
            end else if (done_vec[i]) begin
                next_alarm[i] = 1'b1;
            end else if (sack_vec[i] || ack_vec[i]) begin
                next_alarm[i] = 1'b0;
            end else begin
                next_alarm[i] = alarm[i];
            end
        end
    end
    assign alarm = ALARM_ACTIVE;

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            filt <= '0;
            ALARM_ACTIVE <= '0;
            EVENT_STROBE <= '0;
            irq_stat <= '0;
            WARNING_ALARM <= 1'b0;
            SHUTDOWN_ALARM <= 1'b0;
            IRQ <= 1'b0;
        end else begin
            filt <= done_vec;
            ALARM_ACTIVE <= next_alarm;
            EVENT_STROBE <= event_vec;
            // New event beats a simultaneous clear
            irq_stat <= (irq_stat & ~clr_vec) | event_vec;
            WARNING_ALARM <= |(next_alarm & warn_vec);
            SHUTDOWN_ALARM <= |(next_alarm & ~warn_vec);
            IRQ <= |(((irq_stat & ~clr_vec) | event_vec) & irq_en);
        end
    end
    assign FILTERED_STATE = filt;

    // AXI4-Lite read path, one-cycle answer
    wire ar_take = ARVALID & ARREADY;
    wire next_rvalid = ar_take | (RVALID & ~RREADY);
    wire [5:0] rd_idx = ARADDR[7:2];
    wire rd_ch = rd_idx < 6'(2 * CHANNELS);
    wire [3:0] rd_sel = 4'(rd_idx >> 1);
    wire rd_misalign = ARADDR[1:0] != 2'h0;
    wire rd_wo = ARADDR == IRQ_CLEAR_OFS || ARADDR == ACK_OFS;
    wire rd_map = !rd_misalign && (rd_ch || rd_wo || ARADDR == FILT_STATE_OFS || ARADDR == ALARM_STATE_OFS
        || ARADDR == IRQ_STATUS_OFS || ARADDR == IRQ_ENABLE_OFS);
    wire [31:0] rd_data = !rd_map ? 32'h0000_0000 :
        rd_ch ? (rd_idx[0] ? 32'(delay_set[rd_sel]) : 32'(cfg[rd_sel])) :
        ARADDR == FILT_STATE_OFS ? 32'(filt) :
        ARADDR == ALARM_STATE_OFS ? 32'(ALARM_ACTIVE) :
        ARADDR == IRQ_STATUS_OFS ? 32'(irq_stat) :
        ARADDR == IRQ_ENABLE_OFS ? 32'(irq_en) : 32'h0000_0000;

    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            ARREADY <= 1'b0;
            RVALID <= 1'b0;
            RDATA <= '0;
            RRESP <= RESP_OKAY;
        end else begin
            ARREADY <= ~next_rvalid;
            RVALID <= next_rvalid;
            if (ar_take) begin
                RDATA <= rd_data;
                RRESP <= rd_map ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    sequence rise_s(i);
        !done_vec[i] ##1 done_vec[i];
    endsequence

    event_rise_a: assert property (@(posedge MCLK) disable iff (!NRST)
        rise_s(0) ##0 !ctrl_vec[0] |=> EVENT_STROBE[0] ##1 irq_stat[0])
        else $error("asserted channel gave no event");
    event_log_a: assert property (@(posedge MCLK) disable iff (!NRST)
        EVENT_STROBE[0] |-> $past(!ctrl_vec[0]) && $past(done_vec[0], 1) && !$past(filt[0], 1))
        else $error("event logged for control channel");
    filt_delay_a: assert property (@(posedge MCLK) disable iff (!NRST)
        $rose(FILTERED_STATE[0]) |-> $past(cnt[0]) >= $past(delay_set[0]) && $past(act_vec[0]))
        else $error("filtered state set before delay ran out");
    delay_range_a: assert property (@(posedge MCLK) disable iff (!NRST)
        delay_set[0] >= DELAY_MIN && delay_set[0] <= DELAY_MAX)
        else $error("delay setting out of range");
    bresp_hold_a: assert property (@(posedge MCLK) disable iff (!NRST)
        BVALID && !BREADY |=> BVALID && $stable(BRESP))
        else $error("write response dropped");
    rdata_hold_a: assert property (@(posedge MCLK) disable iff (!NRST)
        RVALID && !RREADY |=> RVALID && $stable(RDATA))
        else $error("read data dropped");
    ack_clear_a: assert property (@(posedge MCLK) disable iff (!NRST)
        alarm[0] && ack_vec[0] && !done_vec[0] |=> !alarm[0])
        else $error("acknowledge left alarm set");
    mon_off_a: assert property (@(posedge MCLK) disable iff (!NRST)
        !mon_vec[4] |=> !ALARM_ACTIVE[4] && !EVENT_STROBE[4])
        else $error("unmonitored channel raised an alarm");
    irq_level_a: assert property (@(posedge MCLK) disable iff (!NRST)
        |(irq_stat & irq_en) && !wr_irq_clr |=> IRQ)
        else $error("enabled status bit gave no interrupt");
endmodule : din_alarm_filter

// [contact_bank.sv]
// External switch contacts wired between supply and the input terminals
`timescale 1ns/1ps
module contact_bank
    import din_alarm_pkg::*;
(
    input wire logic [CHANNELS-1:0] closed,
    input wire logic [CHANNELS-1:0] broken,
    output logic [CHANNELS-1:0] energized
);
    // A broken wire carries no current, whatever the contact does
    assign energized = closed & ~broken;
endmodule : contact_bank

// [din_alarm_filter_test.sv]
// Self-checking bench for the discrete input alarm filter
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
module din_alarm_filter_test
    import din_alarm_pkg::*;
;
    localparam int TK = 4;
    logic MCLK, NRST, EXT_ACK, AWVALID, WVALID, BREADY, ARVALID, RREADY;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID, WARNING_ALARM, SHUTDOWN_ALARM, IRQ;
    logic [CHANNELS-1:0] DISCRETE_INPUT_CHANNEL, FILTERED_STATE, ALARM_ACTIVE, EVENT_STROBE;
    logic [CHANNELS-1:0] closed, broken;
    logic [FLAGS-1:0] GATING_LOGIC_FLAG;
    logic [7:0] AWADDR, ARADDR;
    logic [31:0] WDATA, RDATA, d;
    logic [3:0] WSTRB;
    logic [1:0] BRESP, RRESP, r, bresp;
    int n_mismatch = 0;
    int n_compared = 0;
    int ev_cnt[CHANNELS];
    int n;
    din_alarm_filter #(.TICK_CYCLES(TK)) u_din_alarm_filter (.MCLK(MCLK), .NRST(NRST),
        .DISCRETE_INPUT_CHANNEL(DISCRETE_INPUT_CHANNEL), .GATING_LOGIC_FLAG(GATING_LOGIC_FLAG),
        .EXT_ACK(EXT_ACK), .FILTERED_STATE(FILTERED_STATE), .ALARM_ACTIVE(ALARM_ACTIVE),
        .EVENT_STROBE(EVENT_STROBE), .WARNING_ALARM(WARNING_ALARM), .SHUTDOWN_ALARM(SHUTDOWN_ALARM),
        .IRQ(IRQ), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA),
        .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID),
        .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA),
        .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY));
    contact_bank u_contact_bank (.closed(closed), .broken(broken), .energized(DISCRETE_INPUT_CHANNEL));
    initial begin
        MCLK = 1'b0;
        forever #2 MCLK = ~MCLK;
    end
    always @(posedge MCLK) begin
        for (int i = 0; i < CHANNELS; i++) begin
            if (EVENT_STROBE[i] === 1'b1) ev_cnt[i]++;
        end
    end
    task automatic cyc(input int k);
        repeat (k) @(posedge MCLK);
    endtask : cyc
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        int t;
        bit aw, w;
        aw = 0; w = 0; t = 0;
        AWADDR <= a; WDATA <= v; AWVALID <= 1'b1; WVALID <= 1'b1; BREADY <= 1'b1;
        do begin
            @(posedge MCLK); t++;
            if (!aw && AWREADY === 1'b1) begin aw = 1; AWVALID <= 1'b0; end
            if (!w && WREADY === 1'b1) begin w = 1; WVALID <= 1'b0; end
        end while (!(aw && w) && t < 100);
        do begin @(posedge MCLK); t++; end while (BVALID !== 1'b1 && t < 200);
        bresp = BRESP;
        BREADY <= 1'b0;
        if (t >= 200) `CHK("write answer", 1, 0)
    endtask : wr
    task automatic rd(input logic [7:0] a);
        int t;
        t = 0;
        ARADDR <= a; ARVALID <= 1'b1; RREADY <= 1'b1;
        do begin @(posedge MCLK); t++; end while (ARREADY !== 1'b1 && t < 100);
        ARVALID <= 1'b0;
        do begin @(posedge MCLK); t++; end while (RVALID !== 1'b1 && t < 200);
        d = RDATA; r = RRESP;
        RREADY <= 1'b0;
        if (t >= 200) `CHK("read answer", 1, 0)
    endtask : rd
    task automatic wait_filt(input int ch, input int lim);
        n = 0;
        while (FILTERED_STATE[ch] !== 1'b1 && n < lim) begin @(posedge MCLK); n++; end
    endtask : wait_filt
    task automatic ack_pulse;
        EXT_ACK <= 1'b1;
        cyc(1);
        EXT_ACK <= 1'b0;
        cyc(3);
    endtask : ack_pulse
    task automatic t_regs;
        rd(8'h00); `CHK("cfg0 reset", 32'h0000_0002, d)
        rd(8'h04); `CHK("delay0 reset", 32'h0000_0014, d)
        rd(8'h78); `CHK("unmapped read resp", RESP_SLVERR, r)
        `CHK("unmapped read data", 32'h0, d)
        wr(8'h78, 32'h1); `CHK("unmapped write resp", RESP_SLVERR, bresp)
        wr(8'h0C, 32'hFFFF); rd(8'h0C); `CHK("delay clamp high", 32'h0000_FDE8, d)
        `CHK("write resp okay", RESP_OKAY, bresp)
        WSTRB <= 4'h1;
        wr(8'h0C, 32'h0000_1234);
        rd(8'h0C);
        `CHK("byte lane write", 32'h0000_FD34, d)
        WSTRB <= 4'hF;
        wr(8'h0C, 32'h0); rd(8'h0C); `CHK("delay clamp low", 32'h0000_0008, d)
    endtask : t_regs
    task automatic t_default;
        wr(IRQ_ENABLE_OFS, 32'h1);
        closed[0] <= 1'b1;
        wait_filt(0, 200);
        `CHK("filter not early", 1'b1, n >= 19 * TK)
        `CHK("filter not late", 1'b1, n <= 20 * TK + 8)
        cyc(4);
        `CHK("alarm raised", 1'b1, ALARM_ACTIVE[0])
        `CHK("warning class B", 1'b1, WARNING_ALARM)
        `CHK("no shutdown", 1'b0, SHUTDOWN_ALARM)
        `CHK("irq high", 1'b1, IRQ)
        wr(ACK_OFS, 32'h1); cyc(2);
        `CHK("ack with fault present", 1'b1, ALARM_ACTIVE[0])
        closed[0] <= 1'b0; cyc(8);
        `CHK("filtered follows input", 1'b0, FILTERED_STATE[0])
        `CHK("alarm stays latched", 1'b1, ALARM_ACTIVE[0])
        ack_pulse;
        `CHK("external ack clears", 1'b0, ALARM_ACTIVE[0])
        `CHK("one event", 1, ev_cnt[0])
        wr(IRQ_ENABLE_OFS, 32'h0); cyc(2);
        `CHK("irq masked", 1'b0, IRQ)
        rd(IRQ_STATUS_OFS); `CHK("status sticky", 32'h1, d)
        wr(IRQ_CLEAR_OFS, 32'h1); rd(IRQ_STATUS_OFS); `CHK("status cleared", 32'h0, d)
        wr(IRQ_ENABLE_OFS, 32'h1); cyc(2);
        `CHK("irq stays low", 1'b0, IRQ)
    endtask : t_default
    task automatic t_interrupt;
        closed[1] <= 1'b1; cyc(20);
        closed[1] <= 1'b0; cyc(8);
        closed[1] <= 1'b1;
        wait_filt(1, 100);
        `CHK("restart after gap", 1'b1, n >= 7 * TK)
        `CHK("min delay met", 1'b1, n <= 8 * TK + 8)
        closed[1] <= 1'b0;
        cyc(6);
        `CHK("ch1 still latched", 1'b1, ALARM_ACTIVE[1])
        wr(ACK_OFS, 32'h2);
        cyc(2);
        `CHK("register ack clears", 1'b0, ALARM_ACTIVE[1])
    endtask : t_interrupt
    task automatic t_closed_rest;
        wr(8'h14, 32'h8);
        wr(8'h10, 32'h15);
        closed[2] <= 1'b1; cyc(60);
        `CHK("closed at rest idle", 1'b0, FILTERED_STATE[2])
        broken[2] <= 1'b1;
        wait_filt(2, 100); cyc(2);
        `CHK("wire break asserts", 1'b1, FILTERED_STATE[2])
        `CHK("shutdown class", 1'b1, SHUTDOWN_ALARM)
        `CHK("no warning", 1'b0, WARNING_ALARM)
        broken[2] <= 1'b0; cyc(8);
        `CHK("self ack clears", 1'b0, ALARM_ACTIVE[2])
    endtask : t_closed_rest
    task automatic t_control;
        wr(8'h1C, 32'h8);
        wr(8'h18, 32'h0C);
        closed[3] <= 1'b1;
        wait_filt(3, 100); cyc(2);
        `CHK("control filtered", 1'b1, FILTERED_STATE[3])
        `CHK("control no alarm", 1'b0, ALARM_ACTIVE[3])
        `CHK("control no class out", 1'b0, WARNING_ALARM | SHUTDOWN_ALARM)
        `CHK("control no event", 0, ev_cnt[3])
        closed[3] <= 1'b0; cyc(8);
        `CHK("control released", 1'b0, FILTERED_STATE[3] | ALARM_ACTIVE[3])
    endtask : t_control
    task automatic t_gated;
        wr(8'h24, 32'h8);
        wr(8'h20, 32'hA2);
        closed[4] <= 1'b1; cyc(100);
        `CHK("gated off filtered", 1'b0, FILTERED_STATE[4])
        `CHK("gated off alarm", 1'b0, ALARM_ACTIVE[4])
        GATING_LOGIC_FLAG[4] <= 1'b1;
        wait_filt(4, 100); cyc(2);
        `CHK("counter held clear", 1'b1, n >= 7 * TK)
        `CHK("gated on alarm", 1'b1, ALARM_ACTIVE[4])
        GATING_LOGIC_FLAG[4] <= 1'b0; cyc(4);
        `CHK("gate drop clears", 1'b0, ALARM_ACTIVE[4] | FILTERED_STATE[4])
        closed[4] <= 1'b0;
    endtask : t_gated
    task automatic close_out;
        if (n_mismatch == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : close_out
    initial begin
        // Whole run is about 600 cycles; generous margin before giving up
        #(4 * 20000);
        n_mismatch++;
        close_out;
    end
    initial begin
        NRST = 1'b0; EXT_ACK = 1'b0; closed = '0; broken = '0; GATING_LOGIC_FLAG = '0;
        AWADDR = 8'h00; ARADDR = 8'h00; WDATA = 32'h0; WSTRB = 4'hF;
        AWVALID = 1'b0; WVALID = 1'b0; BREADY = 1'b0; ARVALID = 1'b0; RREADY = 1'b0;
        foreach (ev_cnt[i]) ev_cnt[i] = 0;
        cyc(8);
        NRST <= 1'b1;
        cyc(2);
        t_regs;
        t_default;
        t_interrupt;
        t_closed_rest;
        t_control;
        t_gated;
        close_out;
    end
endmodule : din_alarm_filter_test
